// ---- rtl/ocd_pkg.sv ----
// Constants, field layout and configuration type of the output pair dividers.
// Assumes one 50 MHz clock and a plain register port with 9-bit addresses.
// Function
// [RL1] Low-time bits [7:4] hold the low time in input cycles minus one.
// [RL2] High-time bits [3:0] hold the high time in input cycles minus one.
// [RL3] Bypass bit 7 passes the divider input straight to its output.
// [RL4] Divider A resets into bypass and divider B resets counting.
// [RL5] Divider B counts reset to eleven and divider A counts to zero.
// [RL6] With ignore-alignment bit 6 clear the divider obeys alignment.
// [RL7] Force bit 5 sets the output level, effective only with bit 6 set.
// [RL8] Start-level bit 4 picks the level the divider begins with.
// [RL9] Phase offset bits [3:0] delay the start by that many input cycles.
// [RL10] Direct bit set with source select 10b routes the VCO to the pair.
// [RL11] Direct bit set with select 00b routes the clock input, 01b none.
// [RL12] Divider A feeds pair A and divider B feeds pair B when not direct.
// [RL13] Duty correction is on while bit 0 is clear and off when set.
// [RL14] Counting period is high count plus one plus low count plus one.
package ocd_pkg;

    localparam int          OCD_AW            = 9;
    localparam int          OCD_DW            = 8;
    localparam int          OCD_NREG          = 6;

    localparam logic [8:0]  OCD_OFF_A_COUNTS  = 9'h190;
    localparam logic [8:0]  OCD_OFF_A_CONTROL = 9'h191;
    localparam logic [8:0]  OCD_OFF_A_ROUTING = 9'h192;
    localparam logic [8:0]  OCD_OFF_B_COUNTS  = 9'h193;
    localparam logic [8:0]  OCD_OFF_B_CONTROL = 9'h194;
    localparam logic [8:0]  OCD_OFF_B_ROUTING = 9'h195;
    localparam logic [8:0]  OCD_OFF_STATUS    = 9'h1a0;

    localparam int          OCD_LO_MSB        = 7;
    localparam int          OCD_LO_LSB        = 4;
    localparam int          OCD_HI_MSB        = 3;
    localparam int          OCD_HI_LSB        = 0;
    localparam int          OCD_BYPASS_BIT    = 7;
    localparam int          OCD_NOSYNC_BIT    = 6;
    localparam int          OCD_FORCE_BIT     = 5;
    localparam int          OCD_START_BIT     = 4;
    localparam int          OCD_PHASE_MSB     = 3;
    localparam int          OCD_PHASE_LSB     = 0;
    localparam int          OCD_DIRECT_BIT    = 1;
    localparam int          OCD_DUTY_FIX_DISABLE_BIT    = 0;

    localparam logic [7:0]  OCD_A_COUNTS_RST  = 8'h00;
    localparam logic [7:0]  OCD_A_CONTROL_RST = 8'h80;
    localparam logic [7:0]  OCD_B_COUNTS_RST  = 8'hbb;
    localparam logic [7:0]  OCD_B_CONTROL_RST = 8'h00;
    localparam logic [7:0]  OCD_ROUTING_RST   = 8'h00;
    localparam logic [7:0]  OCD_FULL_MASK     = 8'hff;
    localparam logic [7:0]  OCD_ROUTING_MASK  = 8'h03;
    localparam logic [2:0]  OCD_NO_INDEX      = 3'h7;

    localparam logic [1:0]  OCD_SEL_CLKIN     = 2'h0;
    localparam logic [1:0]  OCD_SEL_NONE      = 2'h1;
    localparam logic [1:0]  OCD_SEL_VCO       = 2'h2;

    typedef struct packed {
        logic       bypass;
        logic       nosync;
        logic       force_lvl;
        logic       start_high;
        logic [3:0] phase;
        logic       direct;
        logic       duty_fix_disable;
        logic [3:0] high_cnt;
        logic [3:0] low_cnt;
    } ocd_cfg_t;

    function automatic ocd_cfg_t ocd_make_cfg(input logic [7:0] counts,
                                              input logic [7:0] control,
                                              input logic [7:0] routing);
        ocd_cfg_t c;
        c.low_cnt          = counts[OCD_LO_MSB:OCD_LO_LSB];
        c.high_cnt         = counts[OCD_HI_MSB:OCD_HI_LSB];
        c.bypass           = control[OCD_BYPASS_BIT];
        c.nosync           = control[OCD_NOSYNC_BIT];
        c.force_lvl        = control[OCD_FORCE_BIT];
        c.start_high       = control[OCD_START_BIT];
        c.phase            = control[OCD_PHASE_MSB:OCD_PHASE_LSB];
        c.direct           = routing[OCD_DIRECT_BIT];
        c.duty_fix_disable = routing[OCD_DUTY_FIX_DISABLE_BIT];
        return c;
    endfunction : ocd_make_cfg

endpackage : ocd_pkg

// ---- rtl/ocd_divider.sv ----
// One channel divider counting rising edges of its sampled input level.
// Assumes src_level and align_req are already in the clock domain.
`timescale 1ns/10ps
module ocd_divider
    import ocd_pkg::*;
(
    input  wire logic     clock,      // System clock.
    input  wire logic     resetn,     // Synchronous reset, active low.
    input  wire ocd_cfg_t cfg,        // Configuration fields.
    input  wire logic     src_level,  // Sampled divider input clock.
    input  wire logic     align_req,  // Alignment request, active high.
    output logic          div_out,    // Divider output level.
    output logic          running     // High while the counter runs.
);

    typedef enum logic [1:0] {
        OCD_ST_HOLD  = 2'b00,
        OCD_ST_DELAY = 2'b01,
        OCD_ST_RUN   = 2'b10
    } ocd_state_t;

    ocd_state_t state;
    ocd_state_t next_state;
    logic [5:0] count;
    logic [5:0] next_count;
    logic       level;
    logic       next_level;
    logic       prev_src;
    logic       next_out;
    logic       tick;
    logic       align_active;
    logic [5:0] hi_len;
    logic [5:0] lo_len;
    logic [5:0] total;
    logic [5:0] high_len;
    logic [5:0] low_len;
    logic [5:0] cur_len;

    assign tick         = src_level & ~prev_src;
    assign align_active = align_req & ~cfg.nosync;                    // RL6
    assign hi_len       = {2'h0, cfg.high_cnt} + 6'h01;               // RL2
    assign lo_len       = {2'h0, cfg.low_cnt} + 6'h01;                // RL1
    assign total        = hi_len + lo_len;                            // RL14
    // Correction balances the halves and leaves the period alone.
    assign high_len     = cfg.duty_fix_disable ? hi_len
                        : ((total + 6'h01) >> 1);                     // RL13
    assign low_len      = total - high_len;
    assign cur_len      = level ? high_len : low_len;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_level = level;
        if (cfg.bypass || align_active)                               // RL3
        begin
            next_state = OCD_ST_HOLD;
            next_count = 6'h00;
            next_level = cfg.start_high;                              // RL8
        end
        else
        begin
            unique case (state)
                OCD_ST_HOLD:
                begin
                    next_count = 6'h00;
                    next_level = cfg.start_high;
                    next_state = (cfg.phase == 4'h0) ? OCD_ST_RUN
                                                     : OCD_ST_DELAY;  // RL9
                end
                OCD_ST_DELAY:
                begin
                    if (tick)
                    begin
                        if (count + 6'h01 >= {2'h0, cfg.phase})       // RL9
                        begin
                            next_state = OCD_ST_RUN;
                            next_count = 6'h00;
                        end
                        else
                        begin
                            next_count = count + 6'h01;
                        end
                    end
                end
                OCD_ST_RUN:
                begin
                    if (tick)
                    begin
                        if (count + 6'h01 >= cur_len)                 // RL14
                        begin
                            next_level = ~level;
                            next_count = 6'h00;
                        end
                        else
                        begin
                            next_count = count + 6'h01;
                        end
                    end
                end
                default:
                begin
                    next_state = OCD_ST_HOLD;
                end
            endcase
        end
        if (cfg.bypass)
            next_out = src_level;                                     // RL3
        else if (align_req && cfg.nosync)
            next_out = cfg.force_lvl;                                 // RL7
        else
            next_out = next_level;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state    <= OCD_ST_HOLD;
            count    <= 6'h00;
            level    <= 1'b0;
            prev_src <= 1'b0;
            div_out  <= 1'b0;
            running  <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            count    <= next_count;
            level    <= next_level;
            prev_src <= src_level;
            div_out  <= next_out;
            running  <= (next_state == OCD_ST_RUN);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_bypass_follow: assert property ( // RL3
        cfg.bypass |=> div_out == $past(src_level))
        else $error("bypassed divider does not follow its input");
    a_hold_start: assert property ( // RL6
        (align_req && !cfg.nosync && !cfg.bypass)
        |=> (div_out == $past(cfg.start_high)) && !running)
        else $error("aligned divider not held at start level");
    a_force_level: assert property ( // RL7
        (align_req && cfg.nosync && !cfg.bypass)
        |=> div_out == $past(cfg.force_lvl))
        else $error("forced level not applied");
    a_flip_point: assert property ( // RL14
        (state == OCD_ST_RUN && tick && count + 6'h01 >= cur_len
         && !cfg.bypass && !align_active) |=> level != $past(level))
        else $error("divider level did not toggle at end of count");
    a_count_bound: assert property ( // RL1
        (state == OCD_ST_RUN && $past(state) == OCD_ST_RUN && $stable(cfg)
         && $past(count) < $past(cur_len)) |-> count < cur_len)
        else $error("divider count beyond programmed time");

endmodule : ocd_divider

// ---- rtl/ocd_pair_router.sv ----
// Output pair selector: divider output or a direct source, as a true and complement pair.
// Assumes all inputs are in the clock domain.
`timescale 1ns/10ps
module ocd_pair_router
    import ocd_pkg::*;
(
    input  wire logic       clock,       // System clock.
    input  wire logic       resetn,      // Synchronous reset, active low.
    input  wire logic       div_level,   // Divider output level.
    input  wire logic       direct,      // Direct-output bit.
    input  wire logic [1:0] src_select,  // Global source select.
    input  wire logic       vco_level,   // Sampled VCO level.
    input  wire logic       clkin_level, // Sampled clock input level.
    output logic            out_first,   // True output of the pair.
    output logic            out_second   // Complement output of the pair.
);

    logic next_first;

    always_comb
    begin
        if (direct && src_select == OCD_SEL_VCO)
            next_first = vco_level;                                   // RL10
        else if (direct && src_select == OCD_SEL_CLKIN)
            next_first = clkin_level;                                 // RL11
        else
            next_first = div_level;                                   // RL12
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            out_first  <= 1'b0;
            out_second <= 1'b1;
        end
        else
        begin
            out_first  <= next_first;
            out_second <= ~next_first;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_direct_vco: assert property ( // RL10
        (direct && src_select == OCD_SEL_VCO)
        |=> out_first == $past(vco_level))
        else $error("VCO not routed to the pair");
    a_direct_clkin: assert property ( // RL11
        (direct && src_select == OCD_SEL_CLKIN)
        |=> out_first == $past(clkin_level))
        else $error("clock input not routed to the pair");
    a_pair_divider: assert property ( // RL12
        (!direct || src_select == OCD_SEL_NONE)
        |=> out_first == $past(div_level) && out_second == !out_first)
        else $error("pair not fed by its divider");

endmodule : ocd_pair_router

// ---- rtl/ocd_top.sv ----
// Two channel dividers with their registers and output pair routing.
// Assumes a plain register port on the same clock, read data one cycle later;
// VCO, clock input and alignment request arrive asynchronously.
`timescale 1ns/10ps
module ocd_top
    import ocd_pkg::*;
(
    input  wire logic        clock,                 // 50 MHz clock.
    input  wire logic        resetn,                // Sync reset, active low.
    input  wire logic [8:0]  reg_addr,              // Register address.
    input  wire logic [7:0]  reg_wdata,             // Write data.
    input  wire logic        reg_write,             // Write strobe.
    input  wire logic        reg_read,              // Read strobe.
    output logic      [7:0]  reg_rdata,             // Read data, next cycle.
    input  wire logic [1:0]  src_select,            // Global source select.
    input  wire logic        vco_level,             // VCO level, async.
    input  wire logic        clkin_level,           // Clock input, async.
    input  wire logic        align_request,         // Alignment, async.
    output logic             pair_a_first_output,   // Pair A true.
    output logic             pair_a_second_output,  // Pair A complement.
    output logic             pair_b_first_output,   // Pair B true.
    output logic             pair_b_second_output   // Pair B complement.
);

    localparam logic [7:0] OCD_RST  [OCD_NREG] = '{
        OCD_A_COUNTS_RST, OCD_A_CONTROL_RST, OCD_ROUTING_RST,
        OCD_B_COUNTS_RST, OCD_B_CONTROL_RST, OCD_ROUTING_RST};
    localparam logic [7:0] OCD_MASK [OCD_NREG] = '{
        OCD_FULL_MASK, OCD_FULL_MASK, OCD_ROUTING_MASK,
        OCD_FULL_MASK, OCD_FULL_MASK, OCD_ROUTING_MASK};

    // Index of a mapped configuration register, or the no-index code.
    function automatic logic [2:0] ocd_reg_index(input logic [8:0] addr);
        logic [8:0] rel;
        rel = addr - OCD_OFF_A_COUNTS;
        if (addr >= OCD_OFF_A_COUNTS && addr <= OCD_OFF_B_ROUTING)
            return rel[2:0];
        else
            return OCD_NO_INDEX;
    endfunction : ocd_reg_index

    logic [2:0] sync_first;
    logic [2:0] sync_second;
    logic       vco_s;
    logic       clkin_s;
    logic       align_s;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            sync_first  <= 3'h0;
            sync_second <= 3'h0;
        end
        else
        begin
            sync_first  <= {align_request, clkin_level, vco_level};
            sync_second <= sync_first;
        end
    end

    assign vco_s   = sync_second[0];
    assign clkin_s = sync_second[1];
    assign align_s = sync_second[2];

    logic [7:0] regs      [OCD_NREG];
    logic [7:0] next_regs [OCD_NREG];
    logic [7:0] next_rdata;
    logic [2:0] wr_index;
    logic [2:0] rd_index;
    logic       div_a_out;
    logic       div_b_out;
    logic       run_a;
    logic       run_b;
    logic [7:0] status;

    assign wr_index = ocd_reg_index(reg_addr);
    assign rd_index = ocd_reg_index(reg_addr);
    assign status   = {4'h0, run_b, run_a, div_b_out, div_a_out};

    always_comb
    begin
        for (int i = 0; i < OCD_NREG; i++)
            next_regs[i] = regs[i];
        if (reg_write && wr_index != OCD_NO_INDEX)
            next_regs[wr_index] = reg_wdata & OCD_MASK[wr_index];
        next_rdata = 8'h00;
        if (reg_read)
        begin
            if (rd_index != OCD_NO_INDEX)
                next_rdata = regs[rd_index];
            else if (reg_addr == OCD_OFF_STATUS)
                next_rdata = status;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < OCD_NREG; i++)
                regs[i] <= OCD_RST[i];                                // RL4 RL5
            reg_rdata <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < OCD_NREG; i++)
                regs[i] <= next_regs[i];
            reg_rdata <= next_rdata;
        end
    end

    ocd_cfg_t cfg_a;
    ocd_cfg_t cfg_b;
    logic     src_a;
    logic     src_b;

    assign cfg_a = ocd_make_cfg(regs[0], regs[1], regs[2]);
    assign cfg_b = ocd_make_cfg(regs[3], regs[4], regs[5]);
    // The divider counts the clock input only when that source is selected.
    assign src_a = (src_select == OCD_SEL_CLKIN) ? clkin_s : vco_s;
    assign src_b = src_a;

    ocd_divider u_div_a (
        .clock     (clock),
        .resetn    (resetn),
        .cfg       (cfg_a),
        .src_level (src_a),
        .align_req (align_s),
        .div_out   (div_a_out),
        .running   (run_a)
    );

    ocd_divider u_div_b (
        .clock     (clock),
        .resetn    (resetn),
        .cfg       (cfg_b),
        .src_level (src_b),
        .align_req (align_s),
        .div_out   (div_b_out),
        .running   (run_b)
    );

    ocd_pair_router u_pair_a (
        .clock       (clock),
        .resetn      (resetn),
        .div_level   (div_a_out),
        .direct      (cfg_a.direct),
        .src_select  (src_select),
        .vco_level   (vco_s),
        .clkin_level (clkin_s),
        .out_first   (pair_a_first_output),
        .out_second  (pair_a_second_output)
    );

    ocd_pair_router u_pair_b (
        .clock       (clock),
        .resetn      (resetn),
        .div_level   (div_b_out),
        .direct      (cfg_b.direct),
        .src_select  (src_select),
        .vco_level   (vco_s),
        .clkin_level (clkin_s),
        .out_first   (pair_b_first_output),
        .out_second  (pair_b_second_output)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_read_data: assert property ( // RL4
        (reg_read && reg_addr == OCD_OFF_A_CONTROL)
        |=> reg_rdata == $past(regs[1]))
        else $error("control read data wrong");
    a_read_idle: assert property (
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_write_store: assert property ( // RL5
        (reg_write && reg_addr == OCD_OFF_B_COUNTS)
        ##1 !(reg_write && reg_addr == OCD_OFF_B_COUNTS)
        |-> regs[3] == $past(reg_wdata) && cfg_b.high_cnt == regs[3][3:0])
        else $error("count register write lost");

endmodule : ocd_top

// ---- tb/test_ocd_top.sv ----
// Self-checking bench for the two output pair dividers in ocd_top.
// Assumes a 50 MHz clock; the bench drives every input itself.
`timescale 1ns/10ps
module test_ocd_top;
    import ocd_pkg::*;

    logic       clock;
    logic       resetn;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic [1:0] src_select;
    logic       vco_level = 1'b0;
    logic       clkin_level;
    logic       align_request;
    logic       pa1, pa2, pb1, pb2;
    logic       vco_run, vco_hold;
    logic [1:0] phase_cnt = 2'h0;
    int         err_total;
    int         check_count;
    logic [7:0] rst_exp [6] = '{8'h00, 8'h80, 8'h00, 8'hbb, 8'h00, 8'h00};
    logic [7:0] ctl_tab [5] = '{8'h10, 8'h00, 8'h20, 8'h60, 8'h40};
    logic       lvl_tab [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

    ocd_top ocd_top_i (
        .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .src_select(src_select),
        .vco_level(vco_level), .clkin_level(clkin_level),
        .align_request(align_request), .pair_a_first_output(pa1),
        .pair_a_second_output(pa2), .pair_b_first_output(pb1),
        .pair_b_second_output(pb2));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // The divider input toggles every two clocks, one rising edge per four.
    always @(posedge clock)
    begin
        phase_cnt <= phase_cnt + 2'h1;
        vco_level <= vco_run ? phase_cnt[1] : vco_hold;
    end

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic chk_reg(input logic [8:0] a, input logic [7:0] e,
                           input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED reg %h expected %h seen %h", a, e, g);
        end
    endtask : chk_reg

    task automatic chk_lvl(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_lvl

    task automatic chk_cnt(input string nm, input int e, input int g);
        check_count++;
        if (g != e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_cnt

    task automatic chk_pair(input string nm, input logic e, input logic t,
                            input logic c);
        chk_lvl(nm, e, t);
        chk_lvl({nm, "_complement"}, ~e, c);
    endtask : chk_pair

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk_reg(a, e, reg_rdata);
    endtask : rd

    task automatic settle;
        repeat (8) @(posedge clock);
        #1;
    endtask : settle

    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (pb1 !== lvl && n < 2000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask : wait_lvl

    // Skips two periods so a count change mid-period cannot disturb it.
    task automatic meas(output int hi, output int per);
        int n;
        int lo;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, lo);
        per = hi + lo;
    endtask : meas

    function automatic int exp_high(input int h, input int l, input bit dcc);
        return dcc ? h + 1 : (h + l + 3) / 2;
    endfunction : exp_high

    initial
    begin
        repeat (40000) @(posedge clock);
        err_total++;
        final_report();
    end

    initial
    begin
        int         n, base, hi, per;
        logic [3:0] h, l;
        logic [3:0] ph [3] = '{4'h0, 4'h3, 4'h9};
        resetn = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        src_select = 2'h2;
        clkin_level = 1'b0;
        align_request = 1'b0;
        vco_run = 1'b0;
        vco_hold = 1'b0;
        err_total = 0;
        check_count = 0;
        void'($urandom(54672));
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(9'h190 + 9'(i), rst_exp[i]);
        wr(9'h196, 8'hff);
        rd(9'h196, 8'h00);
        wr(9'h192, 8'hff);
        rd(9'h192, 8'h03);
        for (int v = 0; v < 2; v++)
        begin
            vco_hold    <= v[0];
            clkin_level <= ~v[0];
            src_select  <= 2'h2;
            wr(9'h192, 8'h00);
            wr(9'h195, 8'h00);
            settle();
            chk_pair("bypass_a", v[0], pa1, pa2);
            wr(9'h192, 8'h02);
            wr(9'h195, 8'h02);
            settle();
            chk_pair("vco_a", v[0], pa1, pa2);
            chk_pair("vco_b", v[0], pb1, pb2);
            src_select <= 2'h0;
            settle();
            chk_pair("clkin_a", ~v[0], pa1, pa2);
            chk_pair("clkin_b", ~v[0], pb1, pb2);
        end
        clkin_level <= 1'b1;
        settle();
        wr(9'h191, 8'h00);
        settle();
        src_select <= 2'h1;
        settle();
        chk_pair("no_effect_a", 1'b0, pa1, pa2);
        wr(9'h192, 8'h00);
        wr(9'h195, 8'h00);
        src_select    <= 2'h2;
        vco_run       <= 1'b1;
        align_request <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            wr(9'h194, ctl_tab[k]);
            rd(9'h194, ctl_tab[k]);
            settle();
            for (int i = 0; i < 20; i++)
            begin
                @(posedge clock);
                #1;
                chk_pair("hold_b", lvl_tab[k], pb1, pb2);
            end
        end
        wr(9'h193, 8'h00);
        wr(9'h195, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            wr(9'h194, {4'h0, ph[k]});
            settle();
            while (phase_cnt !== 2'h3)
            begin
                @(posedge clock);
                #1;
            end
            @(posedge clock);
            align_request <= 1'b0;
            #1;
            wait_lvl(1'b1, n);
            if (k == 0)
                base = n;
            else
                chk_cnt("phase_delay", 4 * int'(ph[k]), n - base);
            if (k < 2)
                align_request <= 1'b1;
        end
        align_request <= 1'b0;
        wr(9'h194, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            h = (k == 0) ? 4'hf : (k == 1) ? 4'h0 : 4'($urandom % 16);
            l = (k < 2) ? 4'hf : 4'($urandom % 16);
            wr(9'h193, {l, h});
            rd(9'h193, {l, h});
            wr(9'h195, {7'h00, k[0]});
            meas(hi, per);
            chk_cnt("period", 4 * (int'(h) + int'(l) + 2), per);
            chk_cnt("high_time", 4 * exp_high(h, l, k[0]), hi);
        end
        final_report();
    end

endmodule : test_ocd_top
